/* rtl/apllcr_pkg.sv */
// Register map, field positions and reset values of the PLL configuration block.
// Assumes a 32-bit Avalon-MM slave with byte offsets as addresses.
package apllcr_pkg;
  localparam logic [7:0] DIV_OFFSET = 8'h60;
  localparam logic [7:0] PWR_OFFSET = 8'h64;
  localparam logic [7:0] FRAC_OFFSET = 8'h68;
  localparam logic [7:0] SPREAD_OFFSET = 8'h6C;
  localparam int MASK_LSB = 16;
  // Divider control fields
  localparam int BYPASS_POS = 15;
  localparam int FIRST_POST_DIVIDER_LSB = 12;
  localparam int FBDIV_LSB = 0;
  localparam logic [15:0] DIV_RESET = 16'h2063;
  // Power control fields
  localparam int PDSEL_POS = 15;
  localparam int PDREQB_POS = 14;
  localparam int PDREQA_POS = 13;
  localparam int DSMOFF_POS = 12;
  localparam int LOCK_POS = 10;
  localparam int SECOND_POST_DIVIDER_LSB = 6;
  localparam int REFDIV_LSB = 0;
  localparam logic [15:0] PWR_RESET = 16'h1041;
  localparam logic [15:0] PWR_RW_MASK = 16'hF1FF;
  // Fraction control fields
  localparam int MPHASE_OFF_POS = 27;
  localparam int OSC_OFF_POS = 26;
  localparam int POST_OFF_POS = 25;
  localparam int DAC_OFF_POS = 24;
  localparam logic [27:0] FRAC_RESET = 28'h0000001;
  // Spread control fields
  localparam int SPREAD_LSB = 8;
  localparam int DIVVAL_LSB = 4;
  localparam int DOWNCTR_POS = 3;
  localparam int SSRST_POS = 2;
  localparam int MODBYP_POS = 1;
  localparam int INTBYP_POS = 0;
  localparam logic [15:0] SPREAD_RESET = 16'h0007;
  localparam logic [15:0] SPREAD_RW_MASK = 16'h1FFF;
endpackage : apllcr_pkg

/* rtl/apllcr_regs.sv */
// PLL configuration and status registers behind an Avalon-MM slave.
// Assumes the analog core reports lock synchronously or via the pin filter here.
// Summary of operation
// - Upper-half mask bits gate lower-half writes, except in the unmasked fraction register
// - Bypass routes reference clock to output
// - First post divider, 1-7, resets two
// - Feedback divider applied literally, reset 0x063
// - Select one: only request B powers down
// - Select zero: feedback, reference or fraction divider change, or A
// - Request B powers down, resets zero
// - Modulator on when zero, resets one
// - Second post divider, 1-7, resets one
// - Reference divider 1-63, resets one
// - Multiphase off bit stops multi-rate outputs
// - Oscillator-output off bit stops buffered clock
// - Post output off stops other outputs
// - Converter off bit powers noise converter
// - Fraction equals value over 2^24, reset one
// - Spread percent is 0.1 times value
// - Direction zero down, one centre
// - Module bypass skips modulator, resets one
// - Integration bypass skips modulator, resets one
//
// Local design decision: the Avalon-MM slave port.
module apllcr_regs (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic pllLockIn,
  input wire logic referenceClockIn,
  input wire logic synthClockIn,
  output logic postDividedOutput,
  output logic [2:0] firstPostDivider,
  output logic [2:0] secondPostDivider,
  output logic [11:0] feedbackDivider,
  output logic [5:0] referenceDivider,
  output logic [23:0] fractionValue,
  output logic pllPowerDown,
  output logic modulatorOff,
  output logic multiphaseOutputOff,
  output logic oscOutputOff,
  output logic postOutputOff,
  output logic dacOff,
  output logic [4:0] spreadAmplitude,
  output logic [3:0] spreadDivider,
  output logic spreadCentre,
  output logic spreadReset,
  output logic spreadModuleBypass,
  output logic spreadIntegrationBypass
);
  logic [15:0] divCtrl_ff;
  logic [15:0] pwrCtrl_ff;
  logic [27:0] fracCtrl_ff;
  logic [15:0] spreadCtrl_ff;
  logic [31:0] readData_ff;
  logic ackPending_ff;
  logic [2:0] lockSync_ff;
  logic lockState_ff;
  logic pdPulse_ff;
  logic [31:0] wrBits;
  logic accessDone;
  logic [15:0] nxt_divCtrl;
  logic [15:0] nxt_pwrCtrl;
  logic [27:0] nxt_fracCtrl;
  logic divChanged;

  // Byte enables widen to a bit mask
  always_comb begin
    wrBits = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
              {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  // One wait cycle per access keeps read data registered
  assign avs_waitrequest = (avs_read | avs_write) & ~ackPending_ff;
  assign accessDone = (avs_read | avs_write) & ackPending_ff;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ackPending_ff <= 1'b0;
    end else if (accessDone) begin
      ackPending_ff <= 1'b0;
    end else if (avs_read | avs_write) begin
      ackPending_ff <= 1'b1;
    end
  end

  function automatic logic [15:0] apllcr_masked(input logic [15:0] oldVal,
                                                 input logic [31:0] data,
                                                 input logic [31:0] lanes);
    logic [15:0] en;
    en = data[31:16] & lanes[31:16];
    apllcr_masked = (oldVal & ~en) | (data[15:0] & en & lanes[15:0]);
  endfunction : apllcr_masked

  always_comb begin
    nxt_divCtrl = divCtrl_ff;
    nxt_pwrCtrl = pwrCtrl_ff;
    nxt_fracCtrl = fracCtrl_ff;
    if (avs_write & accessDone) begin
      if (avs_address == apllcr_pkg::DIV_OFFSET) begin
        nxt_divCtrl = apllcr_masked(divCtrl_ff, avs_writedata, wrBits);
      end
      if (avs_address == apllcr_pkg::PWR_OFFSET) begin
        nxt_pwrCtrl = apllcr_masked(pwrCtrl_ff, avs_writedata, wrBits)
                      & apllcr_pkg::PWR_RW_MASK;
      end
      if (avs_address == apllcr_pkg::FRAC_OFFSET) begin
        // Unmasked register: plain byte-lane write
        nxt_fracCtrl = (fracCtrl_ff & ~wrBits[27:0]) | (avs_writedata[27:0] & wrBits[27:0]);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      divCtrl_ff <= apllcr_pkg::DIV_RESET;
    end else begin
      divCtrl_ff <= nxt_divCtrl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pwrCtrl_ff <= apllcr_pkg::PWR_RESET;
    end else begin
      pwrCtrl_ff <= nxt_pwrCtrl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      fracCtrl_ff <= apllcr_pkg::FRAC_RESET;
    end else begin
      fracCtrl_ff <= nxt_fracCtrl;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      spreadCtrl_ff <= apllcr_pkg::SPREAD_RESET;
    end else if (avs_write & accessDone & (avs_address == apllcr_pkg::SPREAD_OFFSET)) begin
      spreadCtrl_ff <= apllcr_masked(spreadCtrl_ff, avs_writedata, wrBits)
                       & apllcr_pkg::SPREAD_RW_MASK;
    end
  end

  assign divChanged = (nxt_divCtrl[11:0] != divCtrl_ff[11:0])
                    | (nxt_pwrCtrl[5:0] != pwrCtrl_ff[5:0])
                    | (nxt_fracCtrl[23:0] != fracCtrl_ff[23:0]);

  // Change pulse lasts one cycle; analog core stretches as it needs
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pdPulse_ff <= 1'b0;
    end else begin
      pdPulse_ff <= divChanged;
    end
  end

  // select zero uses change or A
  always_comb begin
    if (pwrCtrl_ff[apllcr_pkg::PDSEL_POS]) begin
      pllPowerDown = pwrCtrl_ff[apllcr_pkg::PDREQB_POS];
    end else begin
      pllPowerDown = pdPulse_ff | pwrCtrl_ff[apllcr_pkg::PDREQA_POS];
    end
  end

  // Lock comes from the analog domain: three-stage filter
  always_ff @(posedge core_clk) begin
    if (srst) begin
      lockSync_ff <= 3'h0;
    end else begin
      lockSync_ff <= {lockSync_ff[1:0], pllLockIn};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      lockState_ff <= 1'b0;
    end else if (lockSync_ff[1] == lockSync_ff[2]) begin
      lockState_ff <= lockSync_ff[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      readData_ff <= 32'h0000_0000;
    end else if (avs_read & ~ackPending_ff) begin
      case (avs_address)
        apllcr_pkg::DIV_OFFSET: readData_ff <= {16'h0000, divCtrl_ff};
        apllcr_pkg::PWR_OFFSET: begin
          readData_ff <= {16'h0000, pwrCtrl_ff[15:11], lockState_ff, pwrCtrl_ff[9:0]};
        end
        apllcr_pkg::FRAC_OFFSET: readData_ff <= {4'h0, fracCtrl_ff};
        apllcr_pkg::SPREAD_OFFSET: readData_ff <= {16'h0000, spreadCtrl_ff};
        default: readData_ff <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata = readData_ff;

  assign postDividedOutput = divCtrl_ff[apllcr_pkg::BYPASS_POS] ? referenceClockIn
                                                                  : synthClockIn;
  assign firstPostDivider = divCtrl_ff[apllcr_pkg::FIRST_POST_DIVIDER_LSB +: 3];
  assign feedbackDivider = divCtrl_ff[apllcr_pkg::FBDIV_LSB +: 12];
  assign secondPostDivider = pwrCtrl_ff[apllcr_pkg::SECOND_POST_DIVIDER_LSB +: 3];
  assign referenceDivider = pwrCtrl_ff[apllcr_pkg::REFDIV_LSB +: 6];
  assign modulatorOff = pwrCtrl_ff[apllcr_pkg::DSMOFF_POS];
  assign fractionValue = fracCtrl_ff[23:0];
  assign multiphaseOutputOff = fracCtrl_ff[apllcr_pkg::MPHASE_OFF_POS];
  assign oscOutputOff = fracCtrl_ff[apllcr_pkg::OSC_OFF_POS];
  assign postOutputOff = fracCtrl_ff[apllcr_pkg::POST_OFF_POS];
  assign dacOff = fracCtrl_ff[apllcr_pkg::DAC_OFF_POS];
  assign spreadAmplitude = spreadCtrl_ff[apllcr_pkg::SPREAD_LSB +: 5];
  assign spreadDivider = spreadCtrl_ff[apllcr_pkg::DIVVAL_LSB +: 4];
  assign spreadCentre = spreadCtrl_ff[apllcr_pkg::DOWNCTR_POS];
  assign spreadReset = spreadCtrl_ff[apllcr_pkg::SSRST_POS];
  assign spreadModuleBypass = spreadCtrl_ff[apllcr_pkg::MODBYP_POS];
  assign spreadIntegrationBypass = spreadCtrl_ff[apllcr_pkg::INTBYP_POS];
endmodule : apllcr_regs

/* testbench/apllcr_properties.sv */
// Port-level checks for the PLL configuration registers.
// Assumes one clock, synchronous reset and one wait state per access.
module apllcr_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic pllLockIn,
  input wire logic referenceClockIn,
  input wire logic postDividedOutput,
  input wire logic [11:0] feedbackDivider,
  input wire logic pllPowerDown,
  input wire logic [23:0] fractionValue,
  input wire logic [4:0] spreadAmplitude
);
  logic wr;
  logic wrDiv;
  logic wrPwr;
  logic wrFrac;
  logic wrSpr;
  logic rdDone;
  logic [31:0] wd;
  assign wd = avs_writedata;
  assign wr = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
  assign wrDiv = wr && avs_address == apllcr_pkg::DIV_OFFSET;
  assign wrPwr = wr && avs_address == apllcr_pkg::PWR_OFFSET;
  assign wrFrac = wr && avs_address == apllcr_pkg::FRAC_OFFSET;
  assign wrSpr = wr && avs_address == apllcr_pkg::SPREAD_OFFSET;
  assign rdDone = avs_read && !avs_waitrequest;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_mask;
    wrDiv && wd[27:16] == 12'h000 |=> $stable(feedbackDivider);
  endproperty
  a_mask: assert property (p_mask) else $error("masked write changed divider");
  property p_fbdiv;
    wrDiv && wd[27:16] == 12'hFFF |=> feedbackDivider == $past(wd[11:0]);
  endproperty
  a_fbdiv: assert property (p_fbdiv) else $error("feedback divider not literal");
  property p_bypass;
    wrDiv && wd[31] && wd[15] |=> postDividedOutput == referenceClockIn;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass not routing reference");
  property p_pdb;
    wrPwr && wd[31:30] == 2'h3 && wd[15:14] == 2'h3 |=> pllPowerDown [*2];
  endproperty
  a_pdb: assert property (p_pdb) else $error("request b did not power down");
  property p_lock;
    $stable(pllLockIn) [*8] ##0 rdDone && avs_address == apllcr_pkg::PWR_OFFSET
      |-> avs_readdata[10] == pllLockIn;
  endproperty
  a_lock: assert property (p_lock) else $error("lock bit wrong");
  property p_rsvd;
    rdDone |-> avs_readdata[31:28] == 4'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("upper bits read nonzero");
  property p_frac;
    wrFrac |=> fractionValue == $past(wd[23:0]);
  endproperty
  a_frac: assert property (p_frac) else $error("fraction not stored");
  property p_spread;
    wrSpr && wd[28:24] == 5'h1F |=> spreadAmplitude == $past(wd[12:8]);
  endproperty
  a_spread: assert property (p_spread) else $error("spread amplitude wrong");
  c_div: cover property (wrDiv);
  c_pdb: cover property (wrPwr && wd[14]);
  c_spr: cover property (wrSpr);
endmodule : apllcr_props
bind apllcr_regs apllcr_props u_props (.core_clk, .srst, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .pllLockIn,
  .referenceClockIn, .postDividedOutput, .feedbackDivider, .pllPowerDown, .fractionValue,
  .spreadAmplitude);

/* testbench/testbench.sv */
// Self-checking bench for the PLL configuration registers.
// Assumes the Avalon-MM slave answers after one wait state.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(n, e, g) begin cmpCount++; if ((g) !== (e)) begin errTotal++; \
    $display("mismatch %s expected %0h seen %0h", n, e, g); end end
  logic core_clk, srst, avs_read, avs_write, pllLockIn, referenceClockIn, synthClockIn;
  logic avs_waitrequest, postDividedOutput, pllPowerDown, modulatorOff, multiphaseOutputOff;
  logic oscOutputOff, postOutputOff, dacOff, spreadCentre, spreadReset, spreadModuleBypass;
  logic spreadIntegrationBypass;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable, spreadDivider;
  logic [2:0] firstPostDivider, secondPostDivider;
  logic [11:0] feedbackDivider;
  logic [5:0] referenceDivider;
  logic [23:0] fractionValue;
  logic [4:0] spreadAmplitude;
  int errTotal = 0;
  int cmpCount = 0;
  apllcr_regs dut_u (.core_clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .pllLockIn, .referenceClockIn,
    .synthClockIn, .postDividedOutput, .firstPostDivider, .secondPostDivider,
    .feedbackDivider, .referenceDivider, .fractionValue, .pllPowerDown, .modulatorOff,
    .multiphaseOutputOff, .oscOutputOff, .postOutputOff, .dacOff, .spreadAmplitude,
    .spreadDivider, .spreadCentre, .spreadReset, .spreadModuleBypass, .spreadIntegrationBypass);
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be = 4'hF);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    avs_byteenable <= be;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 40) errTotal++;
    @(negedge core_clk);
  endtask : bus
  task automatic t_reset;
    logic [7:0] adr [5] = '{8'h60, 8'h64, 8'h68, 8'h6C, 8'h70};
    logic [31:0] exp [5] = '{32'h2063, 32'h1041, 32'h1, 32'h7, 32'h0};
    bus(1'b1, 8'h70, 32'hFFFF_FFFF);
    foreach (adr[i]) begin
      bus(1'b0, adr[i], 32'h0);
      `CHK("reset value", exp[i], q)
    end
    $display("test reset done");
  endtask : t_reset
  task automatic t_mask;
    bus(1'b1, 8'h60, 32'h0000_1C80);
    bus(1'b0, 8'h60, 32'h0);
    `CHK("unmasked write", 32'h2063, q)
    bus(1'b1, 8'h60, 32'h0FFF_0C80);
    `CHK("feedback divider", 12'hC80, feedbackDivider)
    `CHK("first post divider", 3'h2, firstPostDivider)
    bus(1'b1, 8'h60, 32'h8000_8000);
    `CHK("bypass on", 1'b0, postDividedOutput)
    bus(1'b1, 8'h60, 32'h8000_0000);
    `CHK("bypass off", 1'b1, postDividedOutput)
    $display("test mask and bypass done");
  endtask : t_mask
  task automatic t_pd;
    bus(1'b1, 8'h64, 32'h003F_0005);
    `CHK("divider change pulse", 1'b1, pllPowerDown)
    `CHK("reference divider", 6'h05, referenceDivider)
    `CHK("second post divider", 3'h1, secondPostDivider)
    @(negedge core_clk);
    `CHK("pulse end", 1'b0, pllPowerDown)
    bus(1'b1, 8'h64, 32'h2000_2000);
    `CHK("request a", 1'b1, pllPowerDown)
    bus(1'b1, 8'h64, 32'h8000_8000);
    `CHK("request a ignored", 1'b0, pllPowerDown)
    bus(1'b1, 8'h64, 32'hC000_C000);
    `CHK("request b", 1'b1, pllPowerDown)
    bus(1'b1, 8'h64, 32'h5000_0000);
    `CHK("request b off", 1'b0, pllPowerDown)
    `CHK("modulator on", 1'b0, modulatorOff)
    $display("test power down done");
  endtask : t_pd
  task automatic t_frac;
    bus(1'b1, 8'h68, 32'h0F12_3456);
    `CHK("output offs", 4'hF, {multiphaseOutputOff, oscOutputOff, postOutputOff, dacOff})
    bus(1'b1, 8'h68, 32'h0000_00AB, 4'h1);
    `CHK("byte lane fraction", 24'h1234AB, fractionValue)
    `CHK("no pulse when selected", 1'b0, pllPowerDown)
    bus(1'b1, 8'h68, 32'h0);
    `CHK("outputs on", 4'h0, {multiphaseOutputOff, oscOutputOff, postOutputOff, dacOff})
    bus(1'b1, 8'h6C, 32'h1FFF_1F58);
    `CHK("spread divider", 4'h5, spreadDivider)
    `CHK("spread fields", 9'h1F8, {spreadAmplitude, spreadCentre, spreadReset,
      spreadModuleBypass, spreadIntegrationBypass})
    $display("test fraction and spread done");
  endtask : t_frac
  task automatic t_lock;
    pllLockIn <= 1'b1;
    repeat (10) @(posedge core_clk);
    bus(1'b1, 8'h64, 32'h0400_0000);
    bus(1'b0, 8'h64, 32'h0);
    `CHK("lock bit", 1'b1, q[10])
    $display("test lock done");
  endtask : t_lock
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : printVerdict
  initial begin
    {srst, avs_read, avs_write, pllLockIn, referenceClockIn, synthClockIn} = 6'h21;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_mask();
    t_pd();
    t_frac();
    t_lock();
    printVerdict();
  end
  // Whole run is about a hundred cycles of 50 ns; the 5000-cycle limit leaves ample margin
  initial begin
    #250000;
    errTotal++;
    printVerdict();
  end
endmodule : testbench
